/* core/irc_irq_request_control.sv */
// Interrupt request control: flags, enables, gating and vector request
`timescale 1ns/100ps
`default_nettype none
module irc_irq_request_control (
    input  wire logic        clk,                          // Core clock, 25 MHz
    input  wire logic        rst_b,                        // Async reset, active low
    input  wire logic        external_edge_irq_pin,        // Edge interrupt pin, async
    input  wire logic        ext_edge_rising_sel,          // 1 rising, 0 falling edge
    input  wire logic [3:0]  port_change_pins,             // Port-change pins, async
    input  wire logic        primary_timer_ovf_stb,        // Timer overflow pulse
    input  wire logic [7:0]  periph_evt_a,                 // Peripheral events, group a
    input  wire logic [7:0]  periph_evt_b,                 // Peripheral events, group b
    input  wire logic        instr_cycle_stb,              // Instruction cycle boundary
    input  wire logic        return_from_irq_instr_stb,    // Return instruction executes
    input  wire logic        sfr_wr_en,                    // Core register write strobe
    input  wire logic [2:0]  sfr_wr_sel,                   // Register select
    input  wire logic [7:0]  sfr_wr_data,                  // Write data
    output logic      [7:0]  irq_control_reg_q,            // Control register contents
    output logic      [7:0]  peripheral_flag_reg_a_q,      // Peripheral flags a
    output logic      [7:0]  peripheral_flag_reg_b_q,      // Peripheral flags b
    output logic      [7:0]  peripheral_enable_reg_a_q,    // Peripheral enables a
    output logic      [7:0]  peripheral_enable_reg_b_q,    // Peripheral enables b
    output logic             irq_request,                  // Combined request level
    output logic             vector_take,                  // Vector now, one clock
    output logic             push_return,                  // Push return address
    output logic [12:0]      vector_addr                   // Program counter load value
);
    // Flag update: hardware set wins over software clear
    function automatic logic [7:0] flag_nxt(
        input logic [7:0] cur,
        input logic       wr,
        input logic [7:0] wd,
        input logic [7:0] set,
        input logic [7:0] mask
    );
        logic [7:0] base;
        base = wr ? wd : cur;
        flag_nxt = (base | set) & mask;
    endfunction

    logic [7:0]  ctl_r, ctl_nxt;
    logic [7:0]  pflag_a_r, pflag_a_nxt;
    logic [7:0]  pflag_b_r, pflag_b_nxt;
    logic [7:0]  pen_a_r, pen_a_nxt;
    logic [7:0]  pen_b_r, pen_b_nxt;
    logic [12:0] vec_addr_r;

    logic        ext_rise;
    logic        ext_fall;
    logic [3:0]  pchg_rise;
    logic [3:0]  pchg_fall;
    logic        ext_evt;
    logic        pchg_evt;
    logic [7:0]  ctl_set;

    logic        wr_ctl;
    logic        wr_flag_a;
    logic        wr_flag_b;
    logic        wr_en_a;
    logic        wr_en_b;

    logic        glb_en;
    logic        grp_en;
    logic        core_hit;
    logic        periph_hit;
    logic        seq_busy;

    // Pins cross into the core clock before anything looks at them
    irc_edge_sync #(
        .W (1)
    ) u_ext_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (external_edge_irq_pin),
        .rise  (ext_rise),
        .fall  (ext_fall)
    );

    irc_edge_sync #(
        .W (4)
    ) u_pchg_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (port_change_pins),
        .rise  (pchg_rise),
        .fall  (pchg_fall)
    );

    assign ext_evt  = ext_edge_rising_sel ? ext_rise : ext_fall;
    assign pchg_evt = |(pchg_rise | pchg_fall);

    // Write decode
    assign wr_ctl    = sfr_wr_en && (sfr_wr_sel == irc_pkg::SEL_CTL);
    assign wr_flag_a = sfr_wr_en && (sfr_wr_sel == irc_pkg::SEL_FLAG_A);
    assign wr_flag_b = sfr_wr_en && (sfr_wr_sel == irc_pkg::SEL_FLAG_B);
    assign wr_en_a   = sfr_wr_en && (sfr_wr_sel == irc_pkg::SEL_EN_A);
    assign wr_en_b   = sfr_wr_en && (sfr_wr_sel == irc_pkg::SEL_EN_B);

    // [RL7] core flags in control
    assign ctl_set = {5'h00, primary_timer_ovf_stb, ext_evt, pchg_evt};

    // [RL2] flags ignore enables
    assign pflag_a_nxt = flag_nxt(pflag_a_r, wr_flag_a, sfr_wr_data, periph_evt_a, irc_pkg::PERIPH_A_MASK);
    assign pflag_b_nxt = flag_nxt(pflag_b_r, wr_flag_b, sfr_wr_data, periph_evt_b, irc_pkg::PERIPH_B_MASK);

    // [RL8] peripheral enable pairs
    assign pen_a_nxt = wr_en_a ? (sfr_wr_data & irc_pkg::PERIPH_A_MASK) : pen_a_r;
    assign pen_b_nxt = wr_en_b ? (sfr_wr_data & irc_pkg::PERIPH_B_MASK) : pen_b_r;

    // Global enable: vector clear beats the return set, which beats a write
    always_comb begin
        ctl_nxt = flag_nxt(ctl_r, wr_ctl, sfr_wr_data, ctl_set, 8'hff);
        // [RL9] vector clears global
        if (vector_take) begin
            ctl_nxt[irc_pkg::CTL_GLOBAL_EN_BIT] = 1'b0;
        // [RL6] return sets global
        end else if (return_from_irq_instr_stb) begin
            ctl_nxt[irc_pkg::CTL_GLOBAL_EN_BIT] = 1'b1;
        end
    end

    // [RL5] reset clears global
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_r     <= irc_pkg::CTL_RST;
            pflag_a_r <= irc_pkg::PFLAG_RST;
            pflag_b_r <= irc_pkg::PFLAG_RST;
            pen_a_r   <= irc_pkg::PEN_RST;
            pen_b_r   <= irc_pkg::PEN_RST;
        end else begin
            ctl_r     <= ctl_nxt;
            pflag_a_r <= pflag_a_nxt;
            pflag_b_r <= pflag_b_nxt;
            pen_a_r   <= pen_a_nxt;
            pen_b_r   <= pen_b_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_addr_r <= 13'h0000;
        end else if (vector_take) begin
            // [RL9] fixed vector
            vec_addr_r <= irc_pkg::VEC_ADDR;
        end
    end

    // [RL3] [RL13] enable fields
    assign glb_en = ctl_r[irc_pkg::CTL_GLOBAL_EN_BIT];
    assign grp_en = ctl_r[irc_pkg::CTL_GROUP_EN_BIT];

    // [RL1] fourteen flag and enable pairs
    assign core_hit = (ctl_r[irc_pkg::CTL_TMR_IF_BIT]  && ctl_r[irc_pkg::CTL_TMR_IE_BIT])
                   || (ctl_r[irc_pkg::CTL_EXT_IF_BIT]  && ctl_r[irc_pkg::CTL_EXT_IE_BIT])
                   || (ctl_r[irc_pkg::CTL_PCHG_IF_BIT] && ctl_r[irc_pkg::CTL_PCHG_IE_BIT]);
    assign periph_hit = |((pflag_a_r & pen_a_r) | (pflag_b_r & pen_b_r));

    // [RL14] combined request
    assign irq_request = glb_en && (core_hit || (grp_en && periph_hit));

    irc_vector_seq u_vec_seq (
        .clk             (clk),
        .rst_b           (rst_b),
        .irq_request     (irq_request),
        .instr_cycle_stb (instr_cycle_stb),
        .vector_take     (vector_take),
        .busy            (seq_busy)
    );

    // [RL9] push with the vector
    assign push_return = vector_take;

    // [RL10] flags stay visible, never cleared by vectoring
    assign irq_control_reg_q         = ctl_r;
    assign peripheral_flag_reg_a_q   = pflag_a_r;
    assign peripheral_flag_reg_b_q   = pflag_b_r;
    assign peripheral_enable_reg_a_q = pen_a_r;
    assign peripheral_enable_reg_b_q = pen_b_r;
    assign vector_addr               = vec_addr_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_flag_set_wins: assert property ( // RL2
        (periph_evt_a != 8'h00) |=> ((peripheral_flag_reg_a_q & $past(periph_evt_a)) == $past(periph_evt_a)))
        else $error("peripheral event lost");
    chk_timer_flag_set: assert property ( // RL7
        primary_timer_ovf_stb |=> irq_control_reg_q[irc_pkg::CTL_TMR_IF_BIT])
        else $error("timer overflow flag not set");
    chk_global_blocks_all: assert property ( // RL3
        !irq_control_reg_q[irc_pkg::CTL_GLOBAL_EN_BIT] |-> !irq_request)
        else $error("request passed with global enable clear");
    chk_global_aborts_seq: assert property ( // RL3
        (seq_busy && !vector_take && !irq_control_reg_q[irc_pkg::CTL_GLOBAL_EN_BIT]) |=> !seq_busy)
        else $error("sequence kept running with global enable clear");
    chk_request_formula: assert property ( // RL14
        irq_request == (irq_control_reg_q[7] && ((|(irq_control_reg_q[2:0] & irq_control_reg_q[5:3]))
            || (irq_control_reg_q[6] && (|((peripheral_flag_reg_a_q & peripheral_enable_reg_a_q)
            | (peripheral_flag_reg_b_q & peripheral_enable_reg_b_q)))))))
        else $error("combined request mismatch");
    chk_vector_clears_global: assert property ( // RL9
        vector_take |=> !irq_control_reg_q[irc_pkg::CTL_GLOBAL_EN_BIT] && vector_addr == irc_pkg::VEC_ADDR)
        else $error("vector did not clear enable or load address");
    chk_vector_pushes: assert property ( // RL9
        vector_take |-> push_return)
        else $error("return address not pushed");
    chk_return_sets_global: assert property ( // RL6
        (return_from_irq_instr_stb && !vector_take) |=> irq_control_reg_q[irc_pkg::CTL_GLOBAL_EN_BIT])
        else $error("return did not set global enable");
    chk_reset_clears_global: assert property ( // RL5
        $rose(rst_b) |-> !irq_control_reg_q[irc_pkg::CTL_GLOBAL_EN_BIT])
        else $error("global enable set after reset");
    chk_flags_kept_vector: assert property ( // RL10
        (vector_take && !sfr_wr_en) |=> (peripheral_flag_reg_a_q & $past(peripheral_flag_reg_a_q))
            == $past(peripheral_flag_reg_a_q))
        else $error("flag lost on vectoring");
    chk_pin_latency: assert property ( // RL12
        (ext_evt && irq_control_reg_q[7] && irq_control_reg_q[4] && !seq_busy && !sfr_wr_en
            && !vector_take) |=> irq_request)
        else $error("pin event did not raise request");

    cov_vector_taken: cover property (vector_take);
    cov_return_taken: cover property (return_from_irq_instr_stb);
    cov_set_clear_clash: cover property (wr_flag_a && (periph_evt_a != 8'h00));
    cov_periph_request: cover property (irq_request && !core_hit);
endmodule // irc_irq_request_control
`default_nettype wire

/* core/irc_pkg.sv */
// Constants, field positions and state encodings for the interrupt request controller
// Overview of operation
// [RL1] Up to fourteen sources, each owning a flag bit and an enable bit.
// [RL2] Flags set on their event regardless of any enable, group or global.
// [RL3] Global enable at control bit 7 passes unmasked requests, else blocks all.
// [RL4] Global enable plus any flagged, enabled source starts vectoring at once; the sequencer starts only at the next instruction boundary.
// [RL5] Every reset clears the global enable.
// [RL6] Return-from-interrupt instruction exits handler and sets the global enable.
// [RL7] Edge pin, port-change and timer flags with enables live in control register.
// [RL8] Peripheral flags and enables in two register pairs; group enable in control.
// [RL9] Taking an interrupt clears global enable, pushes return, loads 0004h.
// [RL10] All flags stay readable in the handler for polling.
// [RL11] Software clears serviced flags before re-enabling, else handler re-enters.
// [RL12] Pin and port-change latency three or four instruction cycles, any length.
// [RL13] Peripheral group enable sits at control bit 6, below global enable.
// [RL14] Request is global AND (core hit OR group enable AND peripheral hit).
package irc_pkg;

    // Control register field positions
    localparam int unsigned CTL_GLOBAL_EN_BIT = 7;
    localparam int unsigned CTL_GROUP_EN_BIT  = 6;
    localparam int unsigned CTL_TMR_IE_BIT  = 5;
    localparam int unsigned CTL_EXT_IE_BIT  = 4;
    localparam int unsigned CTL_PCHG_IE_BIT = 3;
    localparam int unsigned CTL_TMR_IF_BIT  = 2;
    localparam int unsigned CTL_EXT_IF_BIT  = 1;
    localparam int unsigned CTL_PCHG_IF_BIT = 0;

    // Reset values
    localparam logic [7:0] CTL_RST     = 8'h00;
    localparam logic [7:0] PFLAG_RST   = 8'h00;
    localparam logic [7:0] PEN_RST     = 8'h00;

    // Implemented peripheral bits; unused ones read as zero
    localparam logic [7:0] PERIPH_A_MASK = 8'hff;
    localparam logic [7:0] PERIPH_B_MASK = 8'h07;

    // Core register write selects
    localparam logic [2:0] SEL_CTL    = 3'h0;
    localparam logic [2:0] SEL_FLAG_A = 3'h1;
    localparam logic [2:0] SEL_FLAG_B = 3'h2;
    localparam logic [2:0] SEL_EN_A   = 3'h3;
    localparam logic [2:0] SEL_EN_B   = 3'h4;

    // Vectoring
    localparam int unsigned PC_W      = 13;
    localparam logic [12:0] VEC_ADDR  = 13'h0004;
    localparam logic [1:0]  VEC_WAIT  = 2'h3;
    localparam int unsigned SYNC_DEPTH = 2;

    typedef enum logic [1:0] {
        IRC_IDLE = 2'b00,
        IRC_WAIT = 2'b01,
        IRC_TAKE = 2'b10
    } irc_state_t;

endpackage : irc_pkg

/* core/irc_edge_sync.sv */
// Two-stage pin synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module irc_edge_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,    // Core clock
    input  wire logic         rst_b,  // Async reset, active low
    input  wire logic [W-1:0] pin,    // Raw pin levels
    output logic      [W-1:0] rise,   // Rising edge pulse
    output logic      [W-1:0] fall    // Falling edge pulse
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;
endmodule // irc_edge_sync
`default_nettype wire

/* core/irc_vector_seq.sv */
// Vector sequencer: paces an accepted request to instruction-cycle boundaries
`timescale 1ns/100ps
`default_nettype none
module irc_vector_seq (
    input  wire logic clk,             // Core clock
    input  wire logic rst_b,           // Async reset, active low
    input  wire logic irq_request,     // Combined gated request
    input  wire logic instr_cycle_stb, // One pulse per instruction cycle
    output logic      vector_take,     // Vector pulse, one clock
    output logic      busy             // Sequence in progress
);
    irc_pkg::irc_state_t state_r, state_nxt;
    logic [1:0] cnt_r, cnt_nxt;

    // Counting boundaries, not clocks, keeps latency equal for 1- and 2-cycle instructions
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            irc_pkg::IRC_IDLE: begin
                // [RL4] start at the next instruction boundary
                if (irq_request && instr_cycle_stb) begin
                    state_nxt = irc_pkg::IRC_WAIT;
                    cnt_nxt   = 2'h1;
                end
            end
            irc_pkg::IRC_WAIT: begin
                // [RL12] fixed boundary count
                if (!irq_request) begin
                    state_nxt = irc_pkg::IRC_IDLE;
                end else if (instr_cycle_stb) begin
                    if (cnt_r == irc_pkg::VEC_WAIT - 2'h1) begin
                        state_nxt = irc_pkg::IRC_TAKE;
                    end else begin
                        cnt_nxt = cnt_r + 2'h1;
                    end
                end
            end
            irc_pkg::IRC_TAKE: begin
                state_nxt = irc_pkg::IRC_IDLE;
            end
            default: begin
                state_nxt = irc_pkg::IRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= irc_pkg::IRC_IDLE;
            cnt_r   <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign vector_take = (state_r == irc_pkg::IRC_TAKE);
    assign busy        = (state_r != irc_pkg::IRC_IDLE);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_idle_starts_wait: assert property ( // RL4
        (state_r == irc_pkg::IRC_IDLE && irq_request && instr_cycle_stb) |=> state_r == irc_pkg::IRC_WAIT)
        else $error("request at boundary did not start the sequence");
    chk_latency_three_bounds: assert property ( // RL12
        (state_r == irc_pkg::IRC_WAIT && cnt_r == 2'h2 && irq_request && instr_cycle_stb) |=> vector_take)
        else $error("vector not issued on third boundary");
    chk_take_after_stb: assert property ( // RL12
        vector_take |-> $past(instr_cycle_stb) && $past(cnt_r) == 2'h2)
        else $error("vector issued off a boundary");
    cov_vector_issued: cover property (vector_take);
    cov_request_abort: cover property (state_r == irc_pkg::IRC_WAIT && !irq_request);
endmodule // irc_vector_seq
`default_nettype wire

/* test/irc_core_model.sv */
// Core sequencer model: instruction boundaries, return instruction and return stack depth
`timescale 1ns/100ps
`default_nettype none
module irc_core_model #(
    parameter int unsigned CYC = 4  // Clocks per instruction cycle
) (
    input  wire logic       clk,                        // Core clock
    input  wire logic       rst_b,                      // Async reset, active low
    input  wire logic       ret_req,                    // Bench asks for a return
    input  wire logic       push_return,                // Push pulse from the block
    output var  logic       instr_cycle_stb,            // Boundary pulse
    output var  logic       return_from_irq_instr_stb,  // Return executes
    output var  logic [3:0] stack_depth                 // Pushed return addresses
);
    logic [7:0] phase_r;
    logic       ret_pend_r;
    wire  logic bound = (phase_r == 8'(CYC - 1));
    wire  logic ret_go = bound & (ret_pend_r | ret_req);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= 8'h00;
            ret_pend_r <= 1'b0;
            instr_cycle_stb <= 1'b0;
            return_from_irq_instr_stb <= 1'b0;
            stack_depth <= 4'h0;
        end else begin
            phase_r <= bound ? 8'h00 : phase_r + 8'h01;
            instr_cycle_stb <= bound;
            ret_pend_r <= (ret_pend_r | ret_req) & ~bound;
            return_from_irq_instr_stb <= ret_go;
            // push on vector, pop on return
            stack_depth <= stack_depth + 4'(push_return) - 4'(ret_go);
        end
    end
endmodule // irc_core_model
`default_nettype wire

/* test/irc_irq_request_control_tb_top.sv */
// Self-checking bench for the interrupt request controller
`timescale 1ns/100ps
`default_nettype none
module irc_irq_request_control_tb_top;
    logic        clk, rst_b, ext_pin, ext_rise, tmr_stb, ret_req, wr_en;
    logic [3:0]  pc_pins;
    logic [7:0]  ev_a, ev_b, wr_data;
    logic [2:0]  wr_sel;
    logic [7:0]  ctl_q, fa_q, fb_q, ea_q, eb_q;
    logic        irq_req, vtake, push, stb, ret_stb;
    logic [12:0] vaddr;
    logic [3:0]  depth;
    logic [7:0]  lfsr_r, e_ctl, e_fa, e_fb, e_ea, e_eb;
    int          errors, compares;
    localparam logic [7:0] MB = irc_pkg::PERIPH_B_MASK;

    irc_irq_request_control i_irc_irq_request_control (
        .clk(clk), .rst_b(rst_b), .external_edge_irq_pin(ext_pin), .ext_edge_rising_sel(ext_rise),
        .port_change_pins(pc_pins), .primary_timer_ovf_stb(tmr_stb), .periph_evt_a(ev_a),
        .periph_evt_b(ev_b), .instr_cycle_stb(stb), .return_from_irq_instr_stb(ret_stb),
        .sfr_wr_en(wr_en), .sfr_wr_sel(wr_sel), .sfr_wr_data(wr_data), .irq_control_reg_q(ctl_q),
        .peripheral_flag_reg_a_q(fa_q), .peripheral_flag_reg_b_q(fb_q), .peripheral_enable_reg_a_q(ea_q),
        .peripheral_enable_reg_b_q(eb_q), .irq_request(irq_req), .vector_take(vtake),
        .push_return(push), .vector_addr(vaddr));
    irc_core_model i_irc_core_model (
        .clk(clk), .rst_b(rst_b), .ret_req(ret_req), .push_return(push), .instr_cycle_stb(stb),
        .return_from_irq_instr_stb(ret_stb), .stack_depth(depth));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic f_req(input logic [7:0] c, input logic periph_hit);
        return c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) | (c[6] & periph_hit));
    endfunction
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction
    task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_reg(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic cmp_addr(input string nm, input logic [12:0] e, input logic [12:0] g);
        cmp_reg({nm, "_hi"}, {3'h0, e[12:8]}, {3'h0, g[12:8]});
        cmp_reg(nm, e[7:0], g[7:0]);
    endtask
    task automatic check_regs;
        cmp_reg("irq_control_reg", e_ctl, ctl_q);
        cmp_reg("peripheral_flag_reg_a", e_fa, fa_q);
        cmp_reg("peripheral_flag_reg_b", e_fb, fb_q);
        cmp_reg("peripheral_enable_reg_a", e_ea, ea_q);
        cmp_reg("peripheral_enable_reg_b", e_eb, eb_q);
    endtask
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_sel <= s;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic clr;
        for (int s = 0; s < 5; s++) wr(3'(s), 8'h00);
        {e_ctl, e_fa, e_fb, e_ea, e_eb} = '0;
    endtask
    task automatic wait_for(input logic ret, output int n_stb);
        n_stb = 0;
        for (int n = 0; n < 80; n++) begin
            @(posedge clk);
            tmr_stb <= 1'b0;
            ev_b <= 8'h00;
            ret_req <= 1'b0;
            if (stb === 1'b1) n_stb++;
            if ((ret ? ret_stb : vtake) === 1'b1) break;
        end
    endtask
    task automatic conclude;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("[ERR] watchdog expected done seen running");
        conclude();
    end

    initial begin
        logic [7:0] d, d2, en;
        int cnt;
        {rst_b, ext_pin, ext_rise, tmr_stb, ret_req, wr_en, pc_pins, ev_a, ev_b, wr_data, wr_sel} = '0;
        {e_ctl, e_fa, e_fb, e_ea, e_eb} = '0;
        errors = 0;
        compares = 0;
        lfsr_r = 8'h1c;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check_regs;
        cmp_bit("irq_request", 1'b0, irq_req);
        cmp_addr("vector_addr", 13'h0000, vaddr);
        $display("test reset done");
        // Every select, unused ones must not disturb anything
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            if (i == 0) d = d & 8'h7f;
            wr(3'(i), d);
            case (i)
                0: e_ctl = d;
                1: e_fa = d;
                2: e_fb = d & MB;
                3: e_ea = d;
                4: e_eb = d & MB;
                default: ;
            endcase
            check_regs;
            cmp_bit("irq_request", 1'b0, irq_req);
        end
        $display("test registers done");
        // Flags set with every enable off
        clr;
        d = rnd();
        d2 = rnd();
        @(posedge clk);
        ev_a <= d | 8'h01;
        ev_b <= d2;
        tmr_stb <= 1'b1;
        // clearing write in the same cycle loses
        wr_en <= 1'b1;
        wr_sel <= irc_pkg::SEL_FLAG_A;
        wr_data <= 8'h00;
        @(posedge clk);
        {ev_a, ev_b, tmr_stb, wr_en} <= '0;
        #1;
        e_fa = d | 8'h01;
        e_fb = d2 & MB;
        e_ctl = 8'h04;
        check_regs;
        cmp_bit("irq_request", 1'b0, irq_req);
        $display("test flags done");
        // Gating of global, group and individual enables
        for (int i = 0; i < 32; i++) begin
            wr(3'h3, {7'h00, i[3]});
            e_ea = {7'h00, i[3]};
            e_ctl = {i[0], i[1], i[2], 2'b00, i[4], 2'b00};
            wr(3'h0, e_ctl);
            check_regs;
            cmp_bit("irq_request", f_req(e_ctl, i[3]), irq_req);
            wr(3'h0, 8'h00);
        end
        e_ctl = 8'h00;
        $display("test gating done");
        // Vectoring from pin rise, pin fall, port change, timer and group b
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            ext_rise <= (k != 1);
            repeat (6) @(posedge clk);
            clr;
            en = (k < 2) ? 8'h90 : (k == 2) ? 8'h88 : (k == 3) ? 8'ha0 : 8'hc0;
            if (k == 4) wr(3'h4, 8'h04);
            wr(3'h0, en);
            d = rnd();
            @(posedge clk);
            case (k)
                0: ext_pin <= 1'b1;
                1: ext_pin <= 1'b0;
                2: pc_pins <= pc_pins ^ (4'h1 << d[1:0]);
                3: tmr_stb <= 1'b1;
                default: ev_b <= 8'h04;
            endcase
            wait_for(1'b0, cnt);
            cmp_bit("vector_take", 1'b1, vtake);
            cmp_bit("push_return", 1'b1, push);
            if (k < 3) cmp_bit("latency_3_or_4", 1'b1, cnt >= 3 && cnt <= 4);
            #1;
            e_ctl = (en & 8'h7f) | ((k < 2) ? 8'h02 : (k == 2) ? 8'h01 : (k == 3) ? 8'h04 : 8'h00);
            e_fb = (k == 4) ? 8'h04 : 8'h00;
            e_eb = e_fb;
            check_regs;
            cmp_addr("vector_addr", 13'h0004, vaddr);
            cmp_bit("vector_take", 1'b0, vtake);
            cmp_bit("irq_request", 1'b0, irq_req);
            cmp_reg("stack_depth", 8'(k + 1), {4'h0, depth});
        end
        $display("test vectoring done");
        // Return with the flag left set re-enters the handler
        @(posedge clk);
        ret_req <= 1'b1;
        wait_for(1'b0, cnt);
        cmp_bit("vector_take", 1'b1, vtake);
        #1;
        cmp_reg("stack_depth", 8'h05, {4'h0, depth});
        // software clears the serviced flag before returning
        wr(3'h2, 8'h00);
        @(posedge clk);
        ret_req <= 1'b1;
        wait_for(1'b1, cnt);
        @(posedge clk);
        #1;
        e_ctl = 8'hc0;
        e_fb = 8'h00;
        check_regs;
        cmp_bit("irq_request", 1'b0, irq_req);
        cmp_reg("stack_depth", 8'h04, {4'h0, depth});
        $display("test return done");
        conclude();
    end
endmodule // irc_irq_request_control_tb_top
`default_nettype wire
